//--- rtl/ep_desc_pkg.sv
// package: register map, field layout and reset values of the endpoint descriptor bank
package ep_desc_pkg;

  // endpoints 1 to 3
  localparam int unsigned NUM_EP = 3;

  // register offsets within one endpoint's word group (byte addresses)
  localparam logic [11:0] OFF_OUT_Y_BYTE_COUNT = 12'h000;
  localparam logic [11:0] OFF_OUT_BUF_SIZE     = 12'h004;
  localparam logic [11:0] OFF_IN_CONFIG        = 12'h008;
  localparam logic [11:0] OFF_IN_X_BASE        = 12'h00c;
  localparam logic [11:0] OFF_IN_Y_BYTE_COUNT  = 12'h010;
  localparam logic [11:0] OFF_IN_X_BYTE_COUNT  = 12'h014;
  // stride between endpoint groups
  localparam logic [11:0] EP_STRIDE            = 12'h020;
  // endpoint 1 group base
  localparam logic [11:0] EP_BASE              = 12'h020;

  // field positions
  localparam int unsigned COUNT_MSB   = 6;
  localparam int unsigned VALID_BIT   = 7;
  localparam int unsigned IRQEN_BIT   = 2;
  localparam int unsigned STALL_BIT   = 3;
  localparam int unsigned DOUBLE_BUFFER_ENABLE_BIT    = 4;
  localparam int unsigned TOGGLE_BIT  = 5;
  localparam int unsigned ISO_BIT     = 6;
  localparam int unsigned ENABLE_BIT  = 7;
  localparam int unsigned ADDR_LSB_ZEROS = 3;

  // largest legal byte count
  localparam logic [6:0] MAX_COUNT = 7'h40;

  // reset values
  localparam logic [7:0] RST_OUT_Y_BYTE_COUNT = 8'h00;
  localparam logic [7:0] RST_OUT_BUF_SIZE     = 8'h00;
  localparam logic [7:0] RST_IN_CONFIG        = 8'h00;
  localparam logic [7:0] RST_IN_X_BASE        = 8'h00;
  localparam logic [7:0] RST_IN_COUNT         = 8'h80;

  // read-only-zero masks
  localparam logic [7:0] MASK_BUF_SIZE  = 8'h7f;
  localparam logic [7:0] MASK_IN_CONFIG = 8'hfc;

  // register selector
  typedef enum logic [2:0] {
    SEL_OUT_Y_COUNT = 3'b000,
    SEL_OUT_SIZE    = 3'b001,
    SEL_IN_CONFIG   = 3'b010,
    SEL_IN_X_BASE   = 3'b011,
    SEL_IN_Y_COUNT  = 3'b100,
    SEL_IN_X_COUNT  = 3'b101,
    SEL_NONE        = 3'b111
  } reg_sel_t;

endpackage : ep_desc_pkg

//--- rtl/ep_in_engine.sv
// one input endpoint's transaction sequencing: buffer choice, stall, toggle, completion
`timescale 1ns/10ps
module ep_in_engine
  import ep_desc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  config_q,
  input  wire logic [7:0]  x_base_q,
  input  wire logic        x_valid_n,
  input  wire logic        y_valid_n,
  input  wire logic [6:0]  x_count,
  input  wire logic [6:0]  y_count,
  input  wire logic        token,
  input  wire logic        host_ack,
  output logic             service_en,
  output logic             use_y,
  output logic [10:0]      start_addr,
  output logic [6:0]       tx_count,
  output logic             nak,
  output logic             stall_hs,
  output logic             done,
  output logic             irq_pulse
);

  logic enabled;
  logic double_buffer_enable;
  logic sel_y;
  logic cur_empty;

  // decode of the configuration
  assign enabled    = config_q[ENABLE_BIT];
  assign double_buffer_enable       = config_q[DOUBLE_BUFFER_ENABLE_BIT];
  assign sel_y      = double_buffer_enable & config_q[TOGGLE_BIT];
  assign cur_empty  = sel_y ? y_valid_n : x_valid_n;

  // buffer choice and answers, combinational handshake
  assign service_en = enabled;
  assign use_y      = sel_y;
  assign start_addr = {x_base_q, {ADDR_LSB_ZEROS{1'b0}}};
  assign tx_count   = sel_y ? y_count : x_count;
  assign stall_hs   = enabled & token & config_q[STALL_BIT];
  assign nak        = enabled & token & ~config_q[STALL_BIT] & cur_empty;
  assign done       = enabled & host_ack & ~config_q[STALL_BIT] & ~cur_empty;
  assign irq_pulse  = done & config_q[IRQEN_BIT];

endmodule : ep_in_engine

//--- rtl/usb_endpoint_descriptor_regs.sv
// endpoint descriptor register bank for endpoints 1 to 3 with apb slave
// Overview of operation
// - byte count bits 6:0 hold 0 to 64 directly; above 64 undefined.
// - out Y valid flag bit 7: set means full, host OUT gets NAK.
// - out buffer size in bits 6:0, bit 7 reads zero.
// - in interrupt enable bit 2 gates the completion interrupt.
// - stall bit 3 resets to zero; buffer manager sets, software sets or clears.
// - software stall gives one STALL handshake then clears itself.
// - double buffer bit 4: clear uses X only, set lets toggle choose.
// - config bit 5 shows the current data toggle, DATA0 or DATA1.
// - enable bit 7 clear forbids buffer manager service of the endpoint.
// - X base holds address 10:3, three zero bits appended.
// - X base is the start address of each transaction.
// - base address changes only by software writes.
// - in valid flag inverted: clear holds packet, set empty gives NAK.
// - enable bit concerns the buffer manager moving packets.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
module usb_endpoint_descriptor_regs
  import ep_desc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // buffer manager side, one bit or field per endpoint
  input  wire logic [2:0]  in_token,
  input  wire logic [2:0]  in_host_ack,
  input  wire logic [2:0]  out_rx_done,
  input  wire logic [2:0]  bm_stall_set,
  output logic [2:0]       bm_service_en,
  output logic [2:0]       in_use_y,
  output logic [32:0]      in_start_addr,
  output logic [20:0]      in_tx_count,
  output logic [2:0]       in_nak,
  output logic [2:0]       in_stall_hs,
  output logic [2:0]       in_done,
  output logic [2:0]       out_y_nak,
  output logic [20:0]      out_buf_size,
  output logic [2:0]       xfer_irq
);

  // decode an address to endpoint index and register selector
  function automatic logic [4:0] decode(input logic [11:0] a);
    logic [11:0] rel;
    logic [1:0]  ep;
    logic [2:0]  sel;
    rel = a - EP_BASE;
    ep  = rel[6:5];
    sel = SEL_NONE;
    if (a >= EP_BASE && ep < 2'(NUM_EP) && a[1:0] == 2'b00 && rel[4:2] <= 3'd5)
      sel = rel[4:2];
    decode = {ep, sel};
  endfunction : decode

  // storage, one entry per endpoint
  logic [7:0] out_y_count_q  [NUM_EP];
  logic [7:0] out_size_q     [NUM_EP];
  logic [7:0] in_config_q    [NUM_EP];
  logic [7:0] in_x_base_q    [NUM_EP];
  logic [7:0] in_y_count_q   [NUM_EP];
  logic [7:0] in_x_count_q   [NUM_EP];
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic [4:0]  dec;
  logic [1:0]  dec_ep;
  reg_sel_t    dec_sel;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        bad;
  logic [7:0]  wbyte;
  logic [7:0]  rd_mux;

  logic [2:0]  done_w;
  logic [2:0]  irq_w;
  logic [2:0]  stall_hs_w;
  logic [2:0]  use_y_w;

  // apb decode; zero wait states
  assign dec     = decode(paddr);
  assign dec_ep  = dec[4:3];
  assign dec_sel = reg_sel_t'(dec[2:0]);
  assign access  = psel & penable;
  assign bad     = (dec_sel == SEL_NONE);
  assign wr_en   = access & pwrite & ~bad & pstrb[0];
  assign rd_en   = access & ~pwrite;
  assign wbyte   = pwdata[7:0];

  // read selection, reserved bits read zero
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (dec_sel)
      SEL_OUT_Y_COUNT: rd_mux = out_y_count_q[dec_ep];
      SEL_OUT_SIZE:    rd_mux = out_size_q[dec_ep] & MASK_BUF_SIZE;
      SEL_IN_CONFIG:   rd_mux = in_config_q[dec_ep] & MASK_IN_CONFIG;
      SEL_IN_X_BASE:   rd_mux = in_x_base_q[dec_ep];
      SEL_IN_Y_COUNT:  rd_mux = in_y_count_q[dec_ep];
      SEL_IN_X_COUNT:  rd_mux = in_x_count_q[dec_ep];
      default:         rd_mux = 8'h00;
    endcase
  end

  // read data and error registered at the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      if (rd_en)
        prdata_q <= {24'h00_0000, rd_mux};
      if (access)
        pslverr_q <= bad;
    end
  end

  // pready combinational: every access completes in its first access cycle
  assign pready  = psel & penable;
  assign pslverr = access & bad;
  assign prdata  = rd_en ? {24'h00_0000, rd_mux} : prdata_q;

  // per-endpoint registers and sequencing engines
  for (genvar i = 0; i < NUM_EP; i++)
  begin : g_ep
    logic we;
    logic [6:0] size_fld;
    assign we = wr_en && dec_ep == 2'(i);

    ep_in_engine u_eng (
      .pclk       (pclk),
      .presetn    (presetn),
      .config_q   (in_config_q[i]),
      .x_base_q   (in_x_base_q[i]),
      .x_valid_n  (in_x_count_q[i][VALID_BIT]),
      .y_valid_n  (in_y_count_q[i][VALID_BIT]),
      .x_count    (in_x_count_q[i][COUNT_MSB:0]),
      .y_count    (in_y_count_q[i][COUNT_MSB:0]),
      .token      (in_token[i]),
      .host_ack   (in_host_ack[i]),
      .service_en (bm_service_en[i]),
      .use_y      (use_y_w[i]),
      .start_addr (in_start_addr[11*i +: 11]),
      .tx_count   (in_tx_count[7*i +: 7]),
      .nak        (in_nak[i]),
      .stall_hs   (stall_hs_w[i]),
      .done       (done_w[i]),
      .irq_pulse  (irq_w[i])
    );

    // out Y count: software writes; a received packet on an enabled endpoint sets the valid flag
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        out_y_count_q[i] <= RST_OUT_Y_BYTE_COUNT;
      else if (out_rx_done[i] && in_config_q[i][ENABLE_BIT])
        out_y_count_q[i][VALID_BIT] <= 1'b1;   // set wins over a write
      else if (we && dec_sel == SEL_OUT_Y_COUNT)
        out_y_count_q[i] <= wbyte;
    end

    // out buffer size, bit 7 never stored
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        out_size_q[i] <= RST_OUT_BUF_SIZE;
      else if (we && dec_sel == SEL_OUT_SIZE)
        out_size_q[i] <= wbyte & MASK_BUF_SIZE;
    end

    // in config: software fields, stall set by manager, auto-clear, toggle flip
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        in_config_q[i] <= RST_IN_CONFIG;        // stall reset zero
      else
      begin
        if (we && dec_sel == SEL_IN_CONFIG)
          in_config_q[i] <= wbyte & MASK_IN_CONFIG;
        if (stall_hs_w[i])
          in_config_q[i][STALL_BIT] <= 1'b0;
        if (bm_stall_set[i])
          in_config_q[i][STALL_BIT] <= 1'b1;    // manager set wins
        if (done_w[i])
          in_config_q[i][TOGGLE_BIT] <= ~in_config_q[i][TOGGLE_BIT];
      end
    end

    // in X base: only software changes it
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        in_x_base_q[i] <= RST_IN_X_BASE;
      else if (we && dec_sel == SEL_IN_X_BASE)
        in_x_base_q[i] <= wbyte;
    end

    // in counts: completion marks the used buffer empty
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        in_y_count_q[i] <= RST_IN_COUNT;
        in_x_count_q[i] <= RST_IN_COUNT;
      end
      else
      begin
        if (we && dec_sel == SEL_IN_Y_COUNT)
          in_y_count_q[i] <= wbyte;
        if (we && dec_sel == SEL_IN_X_COUNT)
          in_x_count_q[i] <= wbyte;
        if (done_w[i] && use_y_w[i])
          in_y_count_q[i][VALID_BIT] <= 1'b1;
        if (done_w[i] && !use_y_w[i])
          in_x_count_q[i][VALID_BIT] <= 1'b1;
      end
    end

    assign size_fld = out_size_q[i][COUNT_MSB:0];
    assign out_buf_size[7*i +: 7] = size_fld;
    assign out_y_nak[i] = out_y_count_q[i][VALID_BIT];
  end

  // engine results out
  assign in_use_y    = use_y_w;
  assign in_stall_hs = stall_hs_w;
  assign in_done     = done_w;
  assign xfer_irq    = irq_w;

endmodule : usb_endpoint_descriptor_regs

//--- verif/ep_desc_properties.sv
// checker: port-level properties of the endpoint descriptor bank
`timescale 1ns/10ps
module ep_desc_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  out_rx_done,
  input wire logic [2:0]  bm_stall_set,
  input wire logic [2:0]  bm_service_en,
  input wire logic [32:0] in_start_addr,
  input wire logic [2:0]  in_nak,
  input wire logic [2:0]  in_stall_hs,
  input wire logic [2:0]  in_done,
  input wire logic [2:0]  out_y_nak,
  input wire logic [20:0] out_buf_size,
  input wire logic [2:0]  xfer_irq
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write access phase
  wire wr_acc = psel && penable && pwrite;
  // access phase and a stall handshake the manager does not renew
  sequence s_acc; psel && penable; endsequence
  sequence s_stall_taken; (in_stall_hs & ~bm_stall_set) != 3'h0; endsequence
  property p_ready; s_acc |-> pready; endproperty
  property p_err; pslverr |-> psel && penable; endproperty
  property p_stall_clr;
    s_stall_taken |=> (in_stall_hs & $past(in_stall_hs & ~bm_stall_set)) == 3'h0;
  endproperty
  property p_stall_nak; (in_stall_hs & in_nak) == 3'h0; endproperty
  property p_done_nak; (in_done & in_nak) == 3'h0; endproperty
  property p_irq; (xfer_irq & ~in_done) == 3'h0; endproperty
  property p_svc; ((in_done | in_nak | in_stall_hs) & ~bm_service_en) == 3'h0; endproperty
  property p_align;
    {in_start_addr[24:22], in_start_addr[13:11], in_start_addr[2:0]} == 9'h000;
  endproperty
  property p_base; !wr_acc |=> $stable(in_start_addr); endproperty
  property p_size; !wr_acc |=> $stable(out_buf_size); endproperty
  property p_ynak; !wr_acc && out_rx_done == 3'h0 |=> $stable(out_y_nak); endproperty
  a_ready: assert property (p_ready) else $error("pready missing in access");
  a_err: assert property (p_err) else $error("pslverr outside access");
  a_stall_clr: assert property (p_stall_clr) else $error("stall kept");
  a_stall_nak: assert property (p_stall_nak) else $error("stall and nak");
  a_done_nak: assert property (p_done_nak) else $error("done and nak");
  a_irq: assert property (p_irq) else $error("irq without done");
  a_svc: assert property (p_svc) else $error("disabled endpoint served");
  a_align: assert property (p_align) else $error("start address low bits");
  a_base: assert property (p_base) else $error("base moved");
  a_size: assert property (p_size) else $error("size moved");
  a_ynak: assert property (p_ynak) else $error("out flag moved");
endmodule : ep_desc_properties

bind usb_endpoint_descriptor_regs ep_desc_properties u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .pslverr, .out_rx_done, .bm_stall_set, .bm_service_en,
  .in_start_addr, .in_nak, .in_stall_hs, .in_done, .out_y_nak, .out_buf_size, .xfer_irq);

//--- verif/bm_model.sv
// partner: buffer manager strobes toward the descriptor bank
`timescale 1ns/10ps
module bm_model (
  input  wire logic pclk,
  output logic [2:0] token,
  output logic [2:0] host_ack,
  output logic [2:0] rx_done,
  output logic [2:0] stall_set
);
  // idle until the bench asks for a strobe
  initial {token, host_ack, rx_done, stall_set} = 12'h000;
  // one pattern per clock, on whichever endpoints the pattern names
  task automatic put(input logic [11:0] m);
    @(posedge pclk);
    {token, host_ack, rx_done, stall_set} <= m;
    #1;
  endtask : put
endmodule : bm_model

//--- verif/usb_endpoint_descriptor_regs_tb.sv
// testbench: apb register checks and buffer manager traffic
`timescale 1ns/10ps
module usb_endpoint_descriptor_regs_tb;
  import ep_desc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] in_token, in_host_ack, out_rx_done, bm_stall_set, bm_service_en, in_use_y;
  logic [2:0] in_nak, in_stall_hs, in_done, out_y_nak, xfer_irq;
  logic [32:0] in_start_addr;
  logic [20:0] in_tx_count, out_buf_size;
  logic [7:0] v, c;
  int error_cnt = 0, tests_run = 0, cyc = 0, seed = 32'heb98d302;
  // clock and cycle ceiling
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (++cyc > 20000) begin error_cnt++; print_verdict(); end
  usb_endpoint_descriptor_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .in_token, .in_host_ack, .out_rx_done,
    .bm_stall_set, .bm_service_en, .in_use_y, .in_start_addr, .in_tx_count, .in_nak,
    .in_stall_hs, .in_done, .out_y_nak, .out_buf_size, .xfer_irq);
  bm_model part (.pclk, .token(in_token), .host_ack(in_host_ack), .rx_done(out_rx_done),
    .stall_set(bm_stall_set));
  function automatic logic [11:0] ad(input int e, input logic [11:0] o);
    return EP_BASE + EP_STRIDE * 12'(e) + o;
  endfunction : ad
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // reset values, random fields, then transactions per endpoint
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int e = 0; e < 3; e++)
      for (int k = 0; k < 6; k++)
      begin
        apb(0, ad(e, 12'(4 * k)), 0);
        chk("reset", k > 3 ? 32'h80 : 32'h0, rd);
      end
    apb(0, 12'h000, 0);
    chk("unmapped", 1, err);
    $display("end of reset test");
    for (int e = 0; e < 3; e++)
    begin
      v = $random(seed);
      c = v[6:0] % 65;
      apb(1, ad(e, OFF_OUT_Y_BYTE_COUNT), {v[7], c[6:0]});
      apb(0, ad(e, OFF_OUT_Y_BYTE_COUNT), 0);
      chk("ycount", {v[7], c[6:0]}, rd);
      chk("ynak", v[7], out_y_nak[e]);
      apb(1, ad(e, OFF_OUT_BUF_SIZE), {1'b1, c[6:0]});
      apb(0, ad(e, OFF_OUT_BUF_SIZE), 0);
      chk("size", c, rd);
      chk("size port", c, out_buf_size[7*e+:7]);
      apb(1, ad(e, OFF_IN_X_BASE), v);
      #1;
      chk("start", {v, 3'h0}, in_start_addr[11*e+:11]);
      // write with byte lane 0 off must be ignored
      pstrb <= 4'he;
      apb(1, ad(e, OFF_IN_X_BASE), ~v);
      pstrb <= 4'hf;
      #1;
      chk("strobe", {v, 3'h0}, in_start_addr[11*e+:11]);
      v = $random(seed) & 8'hbf;
      apb(1, ad(e, OFF_IN_CONFIG), v);
      apb(0, ad(e, OFF_IN_CONFIG), 0);
      chk("config", v & MASK_IN_CONFIG, rd);
      chk("service", v[7], bm_service_en[e]);
      chk("use y", v[4] & v[5], in_use_y[e]);
    end
    $display("end of field test");
    for (int e = 0; e < 3; e++)
    begin
      apb(1, ad(e, OFF_IN_CONFIG), 8'h84);
      apb(1, ad(e, OFF_IN_X_BYTE_COUNT), 8'h05);
      part.put(12'h200 << e);
      chk("x count", 5, in_tx_count[7*e+:7]);
      chk("ready nak", 0, in_nak[e]);
      part.put(12'h040 << e);
      chk("done", 1, in_done[e]);
      chk("irq", 1, xfer_irq[e]);
      part.put(0);
      apb(0, ad(e, OFF_IN_CONFIG), 0);
      chk("toggle", 8'ha4, rd);
      apb(0, ad(e, OFF_IN_X_BYTE_COUNT), 0);
      chk("x flag", 8'h85, rd);
      part.put(12'h200 << e);
      chk("empty nak", 1, in_nak[e]);
      part.put(0);
      apb(1, ad(e, OFF_IN_Y_BYTE_COUNT), 8'h07);
      apb(1, ad(e, OFF_IN_CONFIG), 8'hb0);
      part.put(12'h200 << e);
      chk("use y", 1, in_use_y[e]);
      chk("y count", 7, in_tx_count[7*e+:7]);
      part.put(12'h040 << e);
      chk("y done", 1, in_done[e]);
      chk("masked irq", 0, xfer_irq[e]);
      part.put(0);
      apb(1, ad(e, OFF_IN_CONFIG), 8'h88);
      part.put(12'h200 << e);
      chk("stall hs", 1, in_stall_hs[e]);
      part.put(0);
      apb(0, ad(e, OFF_IN_CONFIG), 0);
      chk("stall clear", 8'h80, rd);
      part.put(12'h001 << e);
      part.put(0);
      apb(0, ad(e, OFF_IN_CONFIG), 0);
      chk("stall set", 8'h88, rd);
      apb(1, ad(e, OFF_OUT_Y_BYTE_COUNT), 8'h00);
      part.put(12'h008 << e);
      part.put(0);
      chk("rx nak", 1, out_y_nak[e]);
    end
    $display("end of transaction test");
    print_verdict();
  end
endmodule : usb_endpoint_descriptor_regs_tb
